//--- core/peripheral_disable_bank.sv
`timescale 1ns/1ps
`include "pdb_defines.svh"

// Contract
// - Clearing timer6_off keeps timer 6 enabled and running normally.
// - Bit 5 of timer register: one turns timer 5 off, zero enables.
// - Bit 4 of timer register: one turns timer 4 off, zero enables.
// - Bit 0 of timer register: one turns timer 0 off, zero enables.
// - Analog bits 7, 4 and 3 ignore writes and read zero.
// - Bit 6 of timer register: one turns timer 6 off.
// - All implemented bits read/write and reset to zero on every reset.
module peripheral_disable_bank
    import pdb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             timer0_off,
    output logic             timer1_off,
    output logic             timer2_off,
    output logic             timer3_off,
    output logic             timer4_off,
    output logic             timer5_off,
    output logic             timer6_off,
    output logic             dac_off,
    output logic             adc_off,
    output logic             comparator2_off,
    output logic             comparator1_off,
    output logic             zero_cross_off
);

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic pdb_sel_t decode(input logic [11:0] addr);
        case (addr)
            `PDB_TIMER_DIS_OFS:  decode = PDB_SEL_TIMER;
            `PDB_ANALOG_DIS_OFS: decode = PDB_SEL_ANALOG;
            default:             decode = PDB_SEL_NONE;
        endcase
    endfunction : decode

    pdb_sel_t  sel;
    pdb_byte_t timerVal;
    pdb_byte_t analogVal;
    logic      access;
    logic      wrTimer;
    logic      wrAnalog;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;

    // Zero-wait slave: every access phase completes at its first edge.
    // A write needs byte lane 0 strobed, since all data sits there.
    always_comb begin
        sel      = decode(paddr);
        access   = psel & penable;
        wrTimer  = access & pwrite & pstrb[0] & (sel == PDB_SEL_TIMER);
        wrAnalog = access & pwrite & pstrb[0] & (sel == PDB_SEL_ANALOG);
    end

    assign pready  = 1'b1;

    // ------------------------------------------------------------------------
    // Disable registers
    // ------------------------------------------------------------------------
    // Timer register, bits 6..0 writable.
    pdb_disable_reg #(
        .MASK (`PDB_TIMER_DIS_MASK),
        .RSTV (`PDB_TIMER_DIS_RST)
    ) u_timer (
        .clock  (clock),
        .rst_b  (rst_b),
        .wrEn   (wrTimer),
        .wrData (pwdata[7:0]),
        .value  (timerVal)
    );

    // Analog register; the mask keeps bits 7, 4 and 3 at zero.
    pdb_disable_reg #(
        .MASK (`PDB_ANALOG_DIS_MASK),
        .RSTV (`PDB_ANALOG_DIS_RST)
    ) u_analog (
        .clock  (clock),
        .rst_b  (rst_b),
        .wrEn   (wrAnalog),
        .wrData (pwdata[7:0]),
        .value  (analogVal)
    );

    // ------------------------------------------------------------------------
    // Read data and error response
    // ------------------------------------------------------------------------
    // Read data is registered in the setup cycle so it is stable in the
    // access phase; an unmapped address answers with pslverr and zeros.
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            case (sel)
                PDB_SEL_TIMER:  prdata_nxt = {24'h00_0000, timerVal};
                PDB_SEL_ANALOG: prdata_nxt = {24'h00_0000, analogVal};
                PDB_SEL_NONE:   prdata_nxt = 32'h0000_0000;
                default:        prdata_nxt = 32'h0000_0000;
            endcase
            pslverr_nxt = (sel == PDB_SEL_NONE);
        end else if (access) begin
            pslverr_nxt = pslverr_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = pslverr_r & access;

    // ------------------------------------------------------------------------
    // Disable outputs to the peripherals
    // ------------------------------------------------------------------------
    // A zero bit leaves the peripheral enabled and untouched.
    assign timer6_off      = timerVal[`PDB_TMR6_BIT];
    assign timer5_off      = timerVal[`PDB_TMR5_BIT];
    assign timer4_off      = timerVal[`PDB_TMR4_BIT];
    assign timer3_off      = timerVal[`PDB_TMR3_BIT];
    assign timer2_off      = timerVal[`PDB_TMR2_BIT];
    assign timer1_off      = timerVal[`PDB_TMR1_BIT];
    assign timer0_off      = timerVal[`PDB_TMR0_BIT];
    assign dac_off         = analogVal[`PDB_DAC_BIT];
    assign adc_off         = analogVal[`PDB_ADC_BIT];
    assign comparator2_off = analogVal[`PDB_CMP2_BIT];
    assign comparator1_off = analogVal[`PDB_CMP1_BIT];
    assign zero_cross_off  = analogVal[`PDB_ZCD_BIT];

endmodule : peripheral_disable_bank

//--- core/pdb_defines.svh
`ifndef PDB_DEFINES_SVH
`define PDB_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define PDB_TIMER_DIS_OFS   12'h000
`define PDB_ANALOG_DIS_OFS  12'h004

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PDB_TIMER_DIS_RST   8'h00
`define PDB_ANALOG_DIS_RST  8'h00

// ----------------------------------------------------------------------------
// Field positions of the timer disable register
// ----------------------------------------------------------------------------
`define PDB_TMR0_BIT 0
`define PDB_TMR1_BIT 1
`define PDB_TMR2_BIT 2
`define PDB_TMR3_BIT 3
`define PDB_TMR4_BIT 4
`define PDB_TMR5_BIT 5
`define PDB_TMR6_BIT 6

// ----------------------------------------------------------------------------
// Field positions of the analog disable register
// ----------------------------------------------------------------------------
`define PDB_ZCD_BIT  0
`define PDB_CMP1_BIT 1
`define PDB_CMP2_BIT 2
`define PDB_ADC_BIT  5
`define PDB_DAC_BIT  6

// Writable bits: bit 7 of the timer register is outside this block, and
// bits 7, 4 and 3 of the analog register are unimplemented.
`define PDB_TIMER_DIS_MASK  8'h7F
`define PDB_ANALOG_DIS_MASK 8'h67

`endif

//--- core/pdb_pkg.sv
package pdb_pkg;
    // Register selected by an APB address.
    typedef enum logic [2:0] {
        PDB_SEL_NONE   = 3'b001,
        PDB_SEL_TIMER  = 3'b010,
        PDB_SEL_ANALOG = 3'b100
    } pdb_sel_t;

    typedef logic [7:0] pdb_byte_t;
endpackage : pdb_pkg

//--- core/pdb_disable_reg.sv
`timescale 1ns/1ps
`include "pdb_defines.svh"

// One masked 8-bit disable register; masked-off bits stay zero.
module pdb_disable_reg
    import pdb_pkg::*;
#(
    parameter pdb_byte_t MASK  = 8'h00,
    parameter pdb_byte_t RSTV  = 8'h00
) (
    input  wire logic      clock,
    input  wire logic      rst_b,
    input  wire logic      wrEn,
    input  wire pdb_byte_t wrData,
    output pdb_byte_t      value
);

    pdb_byte_t value_r;
    pdb_byte_t value_nxt;

    // ------------------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------------------
    // Writes only reach implemented bits, so unused ones always read zero.
    always_comb begin
        value_nxt = value_r;
        if (wrEn) begin
            value_nxt = wrData & MASK;
        end
    end

    // Synchronous reset returns every bit to zero, that is enabled.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            value_r <= RSTV & MASK;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;

endmodule : pdb_disable_reg

//--- tb/pdb_bank_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Disable bank checker
// ------------------------------------------------------------
module pdb_bank_asserts (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        timer6_off,
    input wire logic        timer5_off,
    input wire logic        timer4_off,
    input wire logic        timer0_off,
    input wire logic        dac_off
);
    // Accesses decoded as the slave should see them.
    wire logic wr  = psel && penable && pwrite && pstrb[0];
    wire logic rd  = psel && penable && !pwrite;
    wire logic wrT = wr && paddr == 12'h000;
    wire logic wrA = wr && paddr == 12'h004;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_tmr6_write: assert property (wrT |=>
        timer6_off == $past(pwdata[6]))
        else $error("timer6 disable bit did not follow the write");
    a_tmr5_write: assert property (wrT |=>
        timer5_off == $past(pwdata[5]))
        else $error("timer5 disable bit did not follow the write");
    a_tmr4_write: assert property (wrT |=>
        timer4_off == $past(pwdata[4]))
        else $error("timer4 disable bit did not follow the write");
    a_tmr0_write: assert property (wrT |=>
        timer0_off == $past(pwdata[0]))
        else $error("timer0 disable bit did not follow the write");
    a_dac_write: assert property (wrA |=> dac_off == $past(pwdata[6]))
        else $error("dac disable bit did not follow the write");
    a_bank_hold: assert property (!wrT && !wrA |=>
        $stable({timer6_off, timer5_off, timer4_off, timer0_off, dac_off}))
        else $error("disable bit changed without a write");
    a_rd_reserved: assert property (rd && paddr == 12'h004 |->
        (prdata[7:0] & 8'h98) == 8'h00) else $error("reserved bit read one");
    a_rd_timer: assert property (rd && paddr == 12'h000 |->
        prdata[6:4] == {timer6_off, timer5_off, timer4_off})
        else $error("timer register read differs from outputs");
    // Reset must clear the timer6, timer5, timer0 and dac bits whatever the bus does meanwhile.
    a_reset_zero: assert property (@(posedge clock) disable iff (1'b0)
        !rst_b |=> !(timer6_off | timer5_off | timer0_off | dac_off))
        else $error("disable bit not cleared by reset");
    cover property (wrT && pwdata[6]);
    cover property (rd && paddr == 12'h004);
    cover property (rd && paddr == 12'h008);
endmodule : pdb_bank_asserts

bind peripheral_disable_bank pdb_bank_asserts pdb_bank_asserts_i (.*);

//--- tb/tb.sv
`timescale 1ns/1ps
`include "pdb_defines.svh"
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module tb import pdb_pkg::*; ;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, x;
    logic [3:0]  pstrb;
    logic [6:0]  tmrOff;
    logic [4:0]  anaOff;
    pdb_byte_t   tm, an;
    logic [39:0] expQ[$];
    int          num_errors, checks;
    peripheral_disable_bank peripheral_disable_bank_i (.clock(clock),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer0_off(tmrOff[0]),
        .timer1_off(tmrOff[1]), .timer2_off(tmrOff[2]),
        .timer3_off(tmrOff[3]), .timer4_off(tmrOff[4]),
        .timer5_off(tmrOff[5]), .timer6_off(tmrOff[6]), .dac_off(anaOff[4]),
        .adc_off(anaOff[3]), .comparator2_off(anaOff[2]),
        .comparator1_off(anaOff[1]), .zero_cross_off(anaOff[0]));
    // Port view of the register being read; an unmapped read shows the error.
    wire logic [7:0] seenVec = (paddr == `PDB_TIMER_DIS_OFS) ? {1'b0, tmrOff}
        : (paddr == `PDB_ANALOG_DIS_OFS)
        ? {1'b0, anaOff[4:3], 2'b00, anaOff[2:0]} : {7'h00, pslverr};
    task check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    // One APB transfer; the request stays up so transfers run back to back.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [3:0] s);
        if (!w) expQ.push_back(a == `PDB_TIMER_DIS_OFS ? {24'h0, tm, tm} :
            a == `PDB_ANALOG_DIS_OFS ? {24'h0, an, an} : 40'h01);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        if (w && s[0] && a == `PDB_TIMER_DIS_OFS)
            tm = d[7:0] & `PDB_TIMER_DIS_MASK;
        if (w && s[0] && a == `PDB_ANALOG_DIS_OFS)
            an = d[7:0] & `PDB_ANALOG_DIS_MASK;
    endtask : apb
    // Watch completed reads and compare against the oldest note.
    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready) begin
            check({prdata, seenVec},
                  expQ.pop_front());
        end
    end
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #(2000 * 50);
        num_errors++;
        close_out();
    end
    // Reset, walking ones, random traffic, then a reset in mid-run.
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {tm, an, x} = {16'h0000, 32'h0000_0008};
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            apb(1'b1, 12'(i / 8 * 4), 32'(1 << i % 8), 4'hF);
            apb(1'b0, 12'(i / 8 * 4), 32'h0000_0000, 4'hF);
        end
        repeat (40) begin
            x = xs(x);
            apb(1'b1, {8'h00, x[21] & x[22], x[20], 2'b00}, x, x[15:12]);
            apb(1'b0, {8'h00, x[21] & x[22], x[20], 2'b00}, x, 4'hF);
        end
        apb(1'b1, `PDB_TIMER_DIS_OFS, 32'h0000_00FF, 4'h1);
        {psel, penable, rst_b} <= 3'b000;
        {tm, an} = 16'h0000;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, `PDB_TIMER_DIS_OFS, 32'h0000_0000, 4'hF);
        apb(1'b0, `PDB_ANALOG_DIS_OFS, 32'h0000_0000, 4'hF);
        {psel, penable} <= 2'b00;
        @(posedge clock);
        close_out();
    end
endmodule : tb
